// >>> fram_dev_end.sv
// Purpose: Memory end of the serial link, 2K byte array with protection
// Assumes: Link pins are sampled by CLK; link clock well below CLK/6
// Notes:   Status is cleared by SYS_RST only; the array is never cleared
//
// How it works
// - Select high: inputs ignored, output off; standby unless pause is low
// - Master reselects before every opcode
// - Sample input on rising, shift output on falling
// - Any link clock rate well below CLK/6, stops allowed
// - Output driven only for read data
// - Pin low plus lock bit blocks status writes
// - Pause low freezes clock and select handling
// - Master changes pause only while clock low
// - Each byte written once fully received
// - Modes 0 and 3 share edge usage
// - 2048 byte locations, each addressable
// - Quarter, half or whole array protection
// - Write disable clears the enable latch
// - Two address bytes, top five bits ignored
// - First byte is opcode; unknown ones ignored
`default_nettype none
module fram_dev_end
  import fram_link_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  // System
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // Link pins
  spi_link_if.dev          LINK,
  // Observation
  output logic             STANDBY,
  output logic       [7:0] STATUS_VIEW
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;
  logic       cs_s;
  logic       sck_s;
  logic       si_s;
  logic       hold_s;
  logic       wp_s;

  // Active-low pins pass inverted so a cleared stage reads as idle
  sync2 #(
    .W (5)
  ) u_pins (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({~LINK.cs_n, LINK.sck, LINK.si, ~LINK.hold_n, ~LINK.wp_n}),
    .q   (pins_s)
  );

  assign cs_s   = ~pins_s[4];
  assign sck_s  = pins_s[3];
  assign si_s   = pins_s[2];
  assign hold_s = ~pins_s[1];
  assign wp_s   = ~pins_s[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    phase_type         phase;
    logic [2:0]        bit_cnt;
    logic [7:0]        shift_in;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        out_sr;
    logic              so_bit;
    logic              drive;
    logic              so_oe;
    logic              wel;
    logic [7:0]        status;
    logic              sck_prev;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;
    logic              standby;
  } dev_type;
  dev_type st_reg;
  dev_type st_next;

  logic [7:0]        mem [DEPTH];
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        mem_q;
  logic              active;
  logic              rise;
  logic              fall;
  logic [7:0]        byte_val;
  logic              byte_done;
  logic [7:0]        status_view;
  logic [1:0]        prot;
  logic              prot_hit;
  logic              sr_locked;

  // Pause freezes all edge handling, including deselect
  assign active    = ~cs_s & hold_s;
  assign rise      = active & sck_s & ~st_reg.sck_prev;
  assign fall      = active & ~sck_s & st_reg.sck_prev;
  assign byte_val  = {st_reg.shift_in[6:0], si_s};
  assign byte_done = rise & (st_reg.bit_cnt == 3'h7);
  assign prot      = st_reg.status[PROT_HI_BIT:PROT_LO_BIT];
  assign sr_locked = st_reg.status[PIN_LOCK_BIT] & ~wp_s;

  always_comb begin
    status_view = st_reg.status;
    status_view[WEL_BIT] = st_reg.wel;
  end

  // Next location is read ahead so the falling edge finds it ready
  always_comb begin
    if (st_reg.phase == PH_ADDR_LO) begin
      rd_addr = {st_reg.addr[ADDR_W-1:8], byte_val};
    end else begin
      rd_addr = st_reg.addr + 11'h001;
    end
  end

  assign mem_q = mem[rd_addr];

  // ----------------------------------------
  // Block protection
  // ----------------------------------------
  always_comb begin
    case (prot)
      PROT_NONE:    prot_hit = 1'b0;
      PROT_QUARTER: prot_hit = st_reg.addr >= QUARTER_BASE;
      PROT_HALF:    prot_hit = st_reg.addr >= HALF_BASE;
      default:      prot_hit = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.sck_prev = sck_s;
    st_next.wr_en    = 1'b0;
    st_next.standby  = cs_s & hold_s;
    if (cs_s && hold_s) begin
      // Partial byte is simply forgotten
      st_next.phase   = PH_OPCODE;
      st_next.bit_cnt = 3'h0;
      st_next.rd      = 1'b0;
      st_next.drive   = 1'b0;
    end else if (rise) begin
      st_next.shift_in = byte_val;
      st_next.bit_cnt  = st_reg.bit_cnt + 3'h1;
    end
    if (byte_done) begin
      case (st_reg.phase)
        PH_OPCODE: begin
          st_next.phase = PH_IGNORE;
          if (byte_val == set_enable_cmd) begin
            st_next.wel = 1'b1;
          end else if (byte_val == write_disable_cmd) begin
            st_next.wel = 1'b0;
          end else if (byte_val == read_status_cmd) begin
            st_next.phase  = PH_STATUS;
            st_next.rd     = 1'b1;
            st_next.out_sr = status_view;
          end else if (byte_val == write_status_cmd) begin
            st_next.phase = PH_STATUS;
          end else if (byte_val == read_cmd) begin
            st_next.phase = PH_ADDR_HI;
            st_next.rd    = 1'b1;
          end else if (byte_val == write_cmd) begin
            st_next.phase = PH_ADDR_HI;
          end
        end
        PH_ADDR_HI: begin
          // Upper five bits are don't care
          st_next.addr[ADDR_W-1:8] = byte_val[ADDR_W-9:0];
          st_next.phase            = PH_ADDR_LO;
        end
        PH_ADDR_LO: begin
          st_next.addr[7:0] = byte_val;
          st_next.phase     = PH_DATA;
          st_next.out_sr    = mem_q;
        end
        PH_DATA: begin
          st_next.addr = st_reg.addr + 11'h001;
          if (st_reg.rd) begin
            st_next.out_sr = mem_q;
          end else if (st_reg.wel && !prot_hit) begin
            // No busy time: committed on the next clock
            st_next.wr_en   = 1'b1;
            st_next.wr_addr = st_reg.addr;
            st_next.wr_data = byte_val;
          end
        end
        PH_STATUS: begin
          if (st_reg.rd) begin
            st_next.out_sr = status_view;
          end else if (st_reg.wel && !sr_locked) begin
            st_next.status = byte_val & STATUS_WR_MASK;
          end
        end
        default: begin
          st_next.phase = PH_IGNORE;
        end
      endcase
    end
    if (fall && st_reg.rd &&
        (st_reg.phase == PH_DATA || st_reg.phase == PH_STATUS)) begin
      st_next.so_bit = st_reg.out_sr[7];
      st_next.out_sr = {st_reg.out_sr[6:0], 1'b0};
      st_next.drive  = 1'b1;
    end
    // Pause tristates but keeps the read position
    st_next.so_oe = st_next.drive & hold_s & ~cs_s;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg         <= '0;
      st_reg.phase   <= PH_OPCODE;
      st_reg.status  <= STATUS_RESET;
      st_reg.standby <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Array
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (st_reg.wr_en) begin
      mem[st_reg.wr_addr] <= st_reg.wr_data;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign LINK.so     = st_reg.so_bit;
  assign LINK.so_oe  = st_reg.so_oe;
  assign STANDBY     = st_reg.standby;
  assign STATUS_VIEW = {st_reg.status[7:2], st_reg.wel, st_reg.status[0]};
endmodule
`default_nettype wire

// >>> fram_host_end.sv
// Purpose: Bus master end: shifts up to four bytes per select period
// Assumes: HALF_DIV of 8 or more, so read data settles before sampling
// Notes:   Returned byte is the last eight bits seen on the output line
`default_nettype none
module fram_host_end
  import fram_link_pkg::*;
#(
  parameter int   HALF_DIV = SCK_HALF_CYC,
  parameter logic CPOL     = 1'b0
) (
  // System
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // Command
  input  wire logic        START,
  input  wire logic  [2:0] CMD_LEN,
  input  wire logic [31:0] CMD_WORD,
  input  wire logic        PAUSE,
  input  wire logic        WP_LEVEL,
  // Answer
  output logic             BUSY,
  output logic             DONE,
  output logic       [7:0] RDATA,
  // Link pins
  spi_link_if.master       LINK
);
  typedef struct packed {
    host_state_type st;
    logic [7:0]     cnt;
    logic           ph;
    logic [5:0]     nbits;
    logic [31:0]    tx;
    logic [7:0]     rx;
    logic           cs_n;
    logic           sck;
    logic           hold_n;
    logic           done;
  } host_type;
  host_type st_reg;
  host_type st_next;

  logic so_s;
  logic expire;

  sync2 #(
    .W (1)
  ) u_so (
    .clk (CLK),
    .rst (SYS_RST),
    .d   (LINK.so_line),
    .q   (so_s)
  );

  assign expire = st_reg.cnt == 8'(HALF_DIV - 1);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    st_next.cnt  = st_reg.cnt + 8'h01;
    // Pause may only move while the clock stays low
    if (!st_reg.sck && !(st_reg.st == HS_SHIFT && expire && st_reg.hold_n)) begin
      st_next.hold_n = ~PAUSE;
    end
    case (st_reg.st)
      HS_IDLE: begin
        st_next.cnt  = 8'h00;
        st_next.cs_n = 1'b1;
        if (START && CMD_LEN != 3'h0) begin
          // Fresh select for every opcode
          st_next.cs_n  = 1'b0;
          st_next.st    = HS_LEAD;
          st_next.tx    = CMD_WORD << (6'(8) * (6'h4 - {3'h0, CMD_LEN}));
          st_next.nbits = {CMD_LEN, 3'h0};
          st_next.ph    = 1'b0;
        end
      end
      HS_LEAD: begin
        if (expire) begin
          st_next.cnt = 8'h00;
          st_next.st  = HS_SHIFT;
          st_next.sck = 1'b0;
        end
      end
      HS_SHIFT: begin
        if (!st_reg.hold_n) begin
          st_next.cnt = st_reg.cnt;
        end else if (expire) begin
          st_next.cnt = 8'h00;
          st_next.ph  = ~st_reg.ph;
          st_next.sck = ~st_reg.ph;
          if (!st_reg.ph) begin
            st_next.rx    = {st_reg.rx[6:0], so_s};
            st_next.nbits = st_reg.nbits - 6'h01;
          end else if (st_reg.nbits == 6'h00) begin
            st_next.st  = HS_TRAIL;
            st_next.sck = CPOL;
            st_next.ph  = 1'b0;
          end else begin
            st_next.tx = {st_reg.tx[30:0], 1'b0};
          end
        end
      end
      default: begin
        if (expire) begin
          st_next.cs_n = 1'b1;
          st_next.done = 1'b1;
          st_next.st   = HS_IDLE;
          st_next.cnt  = 8'h00;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg        <= '0;
      st_reg.st     <= HS_IDLE;
      st_reg.cs_n   <= 1'b1;
      st_reg.hold_n <= 1'b1;
      st_reg.sck    <= CPOL;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign LINK.cs_n   = st_reg.cs_n;
  assign LINK.sck    = st_reg.sck;
  assign LINK.si     = st_reg.tx[31];
  assign LINK.hold_n = st_reg.hold_n;
  assign LINK.wp_n   = WP_LEVEL;
  assign BUSY        = st_reg.st != HS_IDLE;
  assign DONE        = st_reg.done;
  assign RDATA       = st_reg.rx;
endmodule
`default_nettype wire

// >>> fram_link_pkg.sv
// Purpose: Shared constants and types of the serial memory link
// Assumes: 100 MHz system clock on both ends
// Notes:   Status word: pin lock bit 7, protect field 3:2, enable latch 1
`default_nettype none
package fram_link_pkg;
  // ----------------------------------------
  // Array
  // ----------------------------------------
  localparam int ADDR_W    = 11;
  localparam int MEM_DEPTH = 2048;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 11'h600;
  localparam logic [ADDR_W-1:0] HALF_BASE    = 11'h400;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] set_enable_cmd    = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] read_status_cmd   = 8'h05;
  localparam logic [7:0] write_status_cmd  = 8'h01;
  localparam logic [7:0] read_cmd          = 8'h03;
  localparam logic [7:0] write_cmd         = 8'h02;
  // ----------------------------------------
  // Status word
  // ----------------------------------------
  localparam int PIN_LOCK_BIT = 7;
  localparam int PROT_HI_BIT  = 3;
  localparam int PROT_LO_BIT  = 2;
  localparam int WEL_BIT      = 1;
  localparam logic [7:0] STATUS_WR_MASK = 8'h8c;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [1:0] PROT_NONE      = 2'h0;
  localparam logic [1:0] PROT_QUARTER   = 2'h1;
  localparam logic [1:0] PROT_HALF      = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCK_HALF_NS    = 80;
  localparam int SCK_HALF_CYC   = SCK_HALF_NS / CLK_PERIOD_NS;
  localparam int SCK_MAX_MHZ    = 16;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    PH_OPCODE = 3'h0,
    PH_ADDR_HI = 3'h1,
    PH_ADDR_LO = 3'h3,
    PH_DATA    = 3'h2,
    PH_STATUS  = 3'h6,
    PH_IGNORE  = 3'h4
  } phase_type;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_LEAD  = 2'h1,
    HS_SHIFT = 2'h3,
    HS_TRAIL = 2'h2
  } host_state_type;
endpackage
`default_nettype wire

// >>> spi_fram_slave_interface_tb.sv
// Purpose: Self-checking bench, master end facing memory end
// Assumes: Mode 0 and mode 3 pairs side by side, default half divider
// Notes:   Array starts undefined, so every read follows own write
`default_nettype none
module spi_fram_slave_interface_tb;
  import fram_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, start, pause, wp_level, busy, done, standby;
  logic  [2:0] cmd_len;
  logic [31:0] cmd_word;
  logic  [7:0] rdata, status_view;
  logic        done3, standby3;
  logic  [7:0] rdata3, status_view3;
  int          n_mismatch, comparisons, cycles, oe_cycles;
  spi_link_if link();
  spi_link_if link3();
  fram_dev_end fram_dev_end_inst (.CLK(clk), .SYS_RST(sys_rst), .LINK(link),
    .STANDBY(standby), .STATUS_VIEW(status_view));
  fram_host_end fram_host_end_inst (.CLK(clk), .SYS_RST(sys_rst), .START(start),
    .CMD_LEN(cmd_len), .CMD_WORD(cmd_word), .PAUSE(pause), .WP_LEVEL(wp_level),
    .BUSY(busy), .DONE(done), .RDATA(rdata), .LINK(link));
  // Mode 3 pair runs every command alongside the mode 0 pair
  fram_dev_end fram_dev_end_m3_inst (.CLK(clk), .SYS_RST(sys_rst), .LINK(link3),
    .STANDBY(standby3), .STATUS_VIEW(status_view3));
  fram_host_end #(.CPOL(1'b1)) fram_host_end_m3_inst (.CLK(clk), .SYS_RST(sys_rst),
    .START(start), .CMD_LEN(cmd_len), .CMD_WORD(cmd_word), .PAUSE(pause),
    .WP_LEVEL(wp_level), .BUSY(), .DONE(done3), .RDATA(rdata3), .LINK(link3));
  spi_link_properties spi_link_properties_inst (.CLK(clk), .SYS_RST(sys_rst),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .hold_n(link.hold_n),
    .so(link.so), .so_oe(link.so_oe));
  // ----------------------------------------
  // Clock, watchdog, output monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (link.so_oe === 1'b1 || link3.so_oe === 1'b1) oe_cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("ERROR %0t run did not finish", $time);
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // Bounded wait: one select period is about 530 cycles
  task automatic xfer(input logic [2:0] len, input logic [31:0] word);
    int n;
    @(posedge clk);
    start    <= 1'b1;
    cmd_len  <= len;
    cmd_word <= word;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1200) begin
      @(posedge clk);
      n++;
    end
    chk_bit(n < 1200, 1'b1, "transfer completion");
    chk_bit(done3, 1'b1, "mode 3 completion");
    chk_bit(busy, 1'b0, "idle at completion");
  endtask
  task automatic op(input logic [7:0] c);
    xfer(3'h1, {24'h000000, c});
  endtask
  task automatic st_wr(input logic [7:0] d);
    xfer(3'h2, {16'h0000, write_status_cmd, d});
  endtask
  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d);
    xfer(3'h4, {write_cmd, a, d});
  endtask
  task automatic mem_chk(input logic [15:0] a, input logic [7:0] exp);
    xfer(3'h4, {read_cmd, a, 8'h00});
    chk(rdata, exp, "read data");
    chk(rdata3, exp, "mode 3 read data");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_rw();
    op(set_enable_cmd);
    chk(status_view, 8'h02, "latch set");
    chk(status_view3, 8'h02, "mode 3 latch set");
    oe_cycles = 0;
    mem_wr(16'hffff, 8'h5a);
    mem_wr(16'h0000, 8'ha5);
    mem_wr(16'h0600, 8'h33);
    mem_wr(16'h0400, 8'h3c);
    chk_bit(oe_cycles != 0, 1'b0, "output during writes");
    mem_chk(16'h07ff, 8'h5a);
    mem_chk(16'hf800, 8'ha5);
  endtask
  task automatic test_protect();
    st_wr(8'h04);
    chk(status_view, 8'h06, "quarter protect");
    mem_wr(16'h0600, 8'h11);
    mem_wr(16'h05ff, 8'h77);
    mem_chk(16'h0600, 8'h33);
    mem_chk(16'h05ff, 8'h77);
    xfer(3'h2, {16'h0000, read_status_cmd, 8'h00});
    chk(rdata, 8'h06, "status read");
    chk(rdata3, 8'h06, "mode 3 status read");
    st_wr(8'h08);
    mem_wr(16'h0400, 8'h44);
    mem_chk(16'h0400, 8'h3c);
  endtask
  task automatic test_disable();
    op(write_disable_cmd);
    chk(status_view, 8'h08, "latch cleared");
    st_wr(8'h00);
    chk(status_view, 8'h08, "status write refused");
    op(set_enable_cmd);
    st_wr(8'h00);
    op(write_disable_cmd);
    mem_wr(16'h0000, 8'hee);
    mem_chk(16'h0000, 8'ha5);
  endtask
  task automatic test_lock();
    op(set_enable_cmd);
    st_wr(8'h80);
    chk(status_view, 8'h82, "lock set");
    wp_level <= 1'b0;
    st_wr(8'h0c);
    chk(status_view, 8'h82, "locked write");
    wp_level <= 1'b1;
    st_wr(8'h8c);
    chk(status_view, 8'h8e, "pin released");
    mem_wr(16'h0000, 8'h99);
    mem_chk(16'h0000, 8'ha5);
    st_wr(8'h00);
    chk(status_view, 8'h02, "protect off");
  endtask
  task automatic test_bad_opcode();
    oe_cycles = 0;
    xfer(3'h4, {8'hff, 8'h03, 8'h00, 8'h00});
    chk_bit(oe_cycles != 0, 1'b0, "unknown opcode output");
    chk(status_view, 8'h02, "unknown opcode status");
    mem_chk(16'h0000, 8'ha5);
  endtask
  task automatic test_pause();
    fork
      mem_chk(16'h07ff, 8'h5a);
      begin
        repeat (440) @(posedge clk);
        pause <= 1'b1;
        repeat (60) @(posedge clk);
        pause <= 1'b0;
      end
    join
  endtask
  task automatic test_idle();
    repeat (10) @(posedge clk);
    chk_bit(standby, 1'b1, "standby");
    chk_bit(link.so_oe, 1'b0, "idle output");
    chk_bit(standby3, 1'b1, "mode 3 standby");
    chk_bit(link3.so_oe, 1'b0, "mode 3 idle output");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst     = 1'b1;
    start       = 1'b0;
    pause       = 1'b0;
    wp_level    = 1'b1;
    cmd_len     = 3'h0;
    cmd_word    = 32'h00000000;
    n_mismatch  = 0;
    comparisons = 0;
    cycles      = 0;
    oe_cycles   = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(status_view, STATUS_RESET, "status after reset");
    @(posedge clk);
    chk_bit(standby, 1'b1, "standby after reset");
    chk_bit(standby3, 1'b1, "mode 3 standby after reset");
    test_idle();
    test_rw();
    test_protect();
    test_disable();
    test_lock();
    test_bad_opcode();
    test_pause();
    test_idle();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> spi_link_if.sv
// Purpose: Pin bundle between memory end and bus master end
// Assumes: Serial output line is pulled high when nobody drives it
// Notes:   Enable high means the memory end drives the output
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so;
  logic so_oe;
  logic so_line;
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  assign so_line = so_oe ? so : 1'b1;
  modport dev (
    input  cs_n, sck, si, hold_n, wp_n,
    output so, so_oe
  );
  modport master (
    output cs_n, sck, si, hold_n, wp_n,
    input  so_line
  );
endinterface
`default_nettype wire

// >>> spi_link_properties.sv
// Purpose: Timing checks on the serial memory link, both ends being design code
// Assumes: Mode 0 master, link half period of 8 CLK or more
// Notes:   Output latency is 3 CLK, so idle windows allow 5 cycles
`default_nettype none
module spi_link_properties (
  // System
  input wire logic CLK,
  input wire logic SYS_RST,
  // Link lines
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence select_open;
    $fell(cs_n);
  endsequence
  sequence select_close;
    ##[1:1000] $rose(cs_n);
  endsequence
  property quiet_after(logic off);
    off [*5] |-> !so_oe;
  endproperty
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  standby_off_a: assert property (quiet_after(cs_n))
    else $error("output driven while deselected");
  pause_off_a: assert property (quiet_after(!hold_n))
    else $error("output driven while paused");
  so_falling_a: assert property ($changed(so) && so_oe |-> !sck)
    else $error("output moved while link clock high");
  so_hold_a: assert property (sck && so_oe && $past(so_oe) |-> $stable(so))
    else $error("output unstable in high phase");
  si_hold_a: assert property (sck |-> $stable(si))
    else $error("input moved while link clock high");
  pause_timing_a: assert property ($changed(hold_n) |-> !sck)
    else $error("pause moved while link clock high");
  select_idle_a: assert property (select_open |-> !sck)
    else $error("select fell with clock off idle");
  deselect_idle_a: assert property ($rose(cs_n) |-> !sck)
    else $error("select rose with clock off idle");
  select_bound_a: assert property (select_open |-> select_close)
    else $error("select period never closed");
  sck_half_a: assert property ($changed(sck) |=> $stable(sck) [*7])
    else $error("link clock half period too short");
endmodule
`default_nettype wire

// >>> sync2.sv
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Inputs are levels from another timing domain
// Notes:   Only the second stage is visible outside
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;
  sync_type st_reg;
  sync_type st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule
`default_nettype wire
